// [bwm_cfg.svh]
/*
 * Address map, field positions, reset values and arithmetic constants of the
 * breaker wear monitor. Assumes byte addresses on an 8-bit Avalon-MM address.
 */
`ifndef BWM_CFG_SVH
`define BWM_CFG_SVH

// ****************************************************************************
// Register byte addresses
// ****************************************************************************
`define BWM_A_CTRL      8'h00
`define BWM_A_ALM1_CUR  8'h04
`define BWM_A_ALM1_LIM  8'h08
`define BWM_A_ALM2_CUR  8'h0c
`define BWM_A_ALM2_LIM  8'h10
`define BWM_A_CAPACITY  8'h14
`define BWM_A_STATUS    8'h18
`define BWM_A_MASK      8'h1c
`define BWM_A_STATE     8'h20
`define BWM_A_TRIP_TIME 8'h24
`define BWM_A_TRIP_I1   8'h28
`define BWM_A_TRIP_I2   8'h2c
`define BWM_A_TRIP_I3   8'h30
`define BWM_OPS_REGION  3'h2
`define BWM_CURVE_BIT   7

// ****************************************************************************
// Field positions
// ****************************************************************************
`define BWM_CTRL_CLEAR  0
`define BWM_CTRL_EN     1
`define BWM_CTRL_SEL    8
`define BWM_ST_TRIP     4

// ****************************************************************************
// Ranges and reset values (currents in units of 10 A)
// ****************************************************************************
`define BWM_CUR_MAX     14'h2710
`define BWM_LIM_MIN     17'h00001
`define BWM_LIM_MAX     17'h186a0
`define BWM_OPS_RST     17'h186a0
`define BWM_CNT_UNUSED  17'h00001
`define BWM_CNT_SAT     17'h1ffff
`define BWM_DEC_ONE     17'h00001

// ****************************************************************************
// Fixed-point log arithmetic
// ****************************************************************************
`define BWM_LOG_CORR    8'h57
`define BWM_LOG_ONE     9'h100
`define BWM_ROUND_HALF  26'h0000080
`define BWM_EXP_MAXSH   5'h10
`define BWM_DIV_LAST    5'h19
`define BWM_Q_LAST_CLR  3'h1
`define BWM_Q_LAST_TRIP 3'h4
`define BWM_Q_PHASE0    3'h2

`endif

// [bwm_pkg.sv]
/*
 * Types shared by the breaker wear monitor files.
 * Assumes bwm_cfg.svh supplies all numeric constants.
 */
package bwm_pkg;

  // ****************************************************************************
  // Engine states, Gray coded along the normal path
  // ****************************************************************************
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SEG   = 3'b001,
    ST_MUL   = 3'b011,
    ST_DIV   = 3'b010,
    ST_STORE = 3'b110,
    ST_APPLY = 3'b111
  } bwm_state_type;

  // ****************************************************************************
  // Carriers
  // ****************************************************************************
  typedef struct packed {
    logic [13:0] phase3_broken_current;
    logic [13:0] phase2_broken_current;
    logic [13:0] phase1_broken_current;
  } bwm_phase_cur_type;

  typedef struct packed {
    logic [1:0] alarm_on;
    logic [1:0] alarm_off;
  } bwm_event_type;

endpackage : bwm_pkg

// [bwm_log2.sv]
/*
 * Combinational base-2 logarithm, result in Q5.8 fixed point.
 * Assumes a nonzero input; zero yields zero.
 */
`timescale 1ns/1ps
`include "bwm_cfg.svh"

module bwm_log2
  import bwm_pkg::*;
(
  // Operand and result
  input  wire logic [16:0] value_i,
  output wire logic [12:0] log_o
);

  function automatic [4:0] msb_pos(input logic [16:0] v);
    msb_pos = 5'h0;
    for (int i = 0; i < 17; i++) begin
      if (v[i]) begin
        msb_pos = 5'(i);
      end
    end
  endfunction : msb_pos

  wire logic [4:0]  pos;
  wire logic [16:0] norm;
  wire logic [7:0]  frac;
  wire logic [15:0] bend;
  wire logic [15:0] corr;

  assign pos  = msb_pos(value_i);
  assign norm = value_i << (5'h10 - pos);
  assign frac = norm[15:8];
  // A parabola lifts the linear mantissa toward log2(1+f); error stays near 1/100.
  assign bend = 16'({8'h0, frac} * (16'(`BWM_LOG_ONE) - {8'h0, frac}));
  assign corr = 16'(bend[15:8] * `BWM_LOG_CORR);
  assign log_o = (value_i == 17'h0) ? 13'h0 :
                 13'({pos, 8'h00} + {5'h0, frac} + {5'h0, corr[15:8]});

endmodule : bwm_log2

// [bwm_monitor.sv]
/*
 * Breaker wear monitor: trip capture, curve interpolation, operations-left
 * counters, two alarm channels, events, interrupt and an Avalon-MM slave.
 * Assumes trip lines, currents and time stamp come from logic on core_clk_i.
 */
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "bwm_cfg.svh"

// Behaviour
// - Each of the three pole currents is captured and used independently.
// - Currents latch when the selected supervised trip output rises.
// - A curve of eight current/count points is held in registers.
// - Points above breaker capacity with count one are skipped.
// - Currents between valid points two to eight are log-interpolated.
// - Permitted count follows a/I^n computed in the log domain.
// - Two alarm channels each own a current level and a limit.
// - An alarm is high while its smallest counter is below its limit.
// - Set and clear events are issued only when separately enabled.
// - Clear loads each counter with the count at its alarm current.
// - Three counters per channel; the smallest feeds the comparison.
// - A trip lowers counters by permitted-at-alarm over permitted-at-current.
// - A phase current below the alarm level lowers the counter by one.
// - The latest trip time stamp and three currents are retained.
// - Alarm currents clamp to 0..100.00 kA, limits to 1..100000.
module bwm_monitor
  import bwm_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              arst_n_i,
  // Avalon-MM slave
  input  wire logic [7:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // Protection side
  input  wire logic [7:0]        trip_i,
  input  wire bwm_phase_cur_type broken_current_i,
  input  wire logic [31:0]       time_stamp_i,
  // Output matrix, event log, interrupt
  output logic      [1:0]        alarm_o,
  output bwm_event_type          event_o,
  output logic                   irq_o
);

  // ****************************************************************************
  // Helpers
  // ****************************************************************************
  function automatic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                  input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  function automatic [13:0] clamp_cur(input logic [31:0] v);
    clamp_cur = (v > 32'(`BWM_CUR_MAX)) ? `BWM_CUR_MAX : v[13:0];
  endfunction : clamp_cur

  function automatic [16:0] clamp_lim(input logic [31:0] v);
    if (v < 32'(`BWM_LIM_MIN)) begin
      clamp_lim = `BWM_LIM_MIN;
    end else if (v > 32'(`BWM_LIM_MAX)) begin
      clamp_lim = `BWM_LIM_MAX;
    end else begin
      clamp_lim = v[16:0];
    end
  endfunction : clamp_lim

  function automatic [16:0] exp2r(input logic [12:0] x);
    logic [7:0]  f;
    logic [15:0] bend;
    logic [15:0] corr;
    logic [8:0]  m;
    logic [25:0] sh;
    f    = x[7:0];
    bend = 16'({8'h0, f} * (16'(`BWM_LOG_ONE) - {8'h0, f}));
    corr = 16'(bend[15:8] * `BWM_LOG_CORR);
    m    = 9'(`BWM_LOG_ONE + {1'b0, f} - {1'b0, corr[15:8]});
    sh   = 26'({17'h0, m} << x[12:8]);
    sh   = 26'(sh + `BWM_ROUND_HALF);
    exp2r = (x[12:8] > `BWM_EXP_MAXSH) ? `BWM_CNT_SAT : sh[24:8];
  endfunction : exp2r

  function automatic [16:0] min3(input logic [16:0] a, input logic [16:0] b,
                                 input logic [16:0] c);
    logic [16:0] m;
    m = (a < b) ? a : b;
    min3 = (m < c) ? m : c;
  endfunction : min3

  // ****************************************************************************
  // Reset release
  // ****************************************************************************
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {rst_n, rst_q1} <= 2'b00;
    end else begin
      {rst_n, rst_q1} <= {rst_q1, 1'b1};
    end
  end

  // ****************************************************************************
  // Storage
  // ****************************************************************************
  logic [3:0]        evt_en;
  logic [2:0]        trip_sel;
  logic [13:0]       alm_cur  [0:1];
  logic [16:0]       alm_lim  [0:1];
  logic [13:0]       capacity;
  logic [4:0]        status;
  logic [4:0]        mask;
  logic [13:0]       pt_cur   [0:7];
  logic [16:0]       pt_cnt   [0:7];
  logic [16:0]       ops_left [0:5];
  logic [31:0]       trip_time;
  bwm_phase_cur_type trip_cur;
  bwm_phase_cur_type job_cur;
  logic              trip_q;
  logic              clr_pend;
  logic              trip_pend;
  logic              job_trip;
  bwm_state_type     state;
  logic [2:0]        qidx;
  logic [2:0]        seg;
  logic              flat;
  logic [16:0]       flat_cnt;
  logic [12:0]       base;
  logic [12:0]       dvs;
  logic [39:0]       div;
  logic [4:0]        step;
  logic [12:0]       logres   [0:4];
  logic [31:0]       rd_mux;

  // ****************************************************************************
  // Bus decode
  // ****************************************************************************
  wire logic        acc      = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
  wire logic        wr       = avs_write_i & acc;
  wire logic [31:0] wdat     = merge(rd_mux, avs_writedata_i, avs_byteenable_i);
  wire logic        a_curve  = avs_address_i[`BWM_CURVE_BIT];
  wire logic [2:0]  a_pt     = avs_address_i[5:3];
  wire logic        a_ops    = (avs_address_i[7:5] == `BWM_OPS_REGION) &
                               (avs_address_i[3:2] != 2'h3);
  wire logic [2:0]  a_ops_ix = 3'({avs_address_i[4], 2'h0} - {2'h0, avs_address_i[4]}) +
                               {1'b0, avs_address_i[3:2]};
  wire logic        clr_cmd  = wr & (avs_address_i == `BWM_A_CTRL) &
                               wdat[`BWM_CTRL_CLEAR];
  wire logic        st_w1c   = wr & (avs_address_i == `BWM_A_STATUS);

  always_comb begin
    rd_mux = 32'h0;
    case (avs_address_i)
      `BWM_A_CTRL: begin
        rd_mux[`BWM_CTRL_EN +: 4]  = evt_en;
        rd_mux[`BWM_CTRL_SEL +: 3] = trip_sel;
      end
      `BWM_A_ALM1_CUR:  rd_mux[13:0] = alm_cur[0];
      `BWM_A_ALM1_LIM:  rd_mux[16:0] = alm_lim[0];
      `BWM_A_ALM2_CUR:  rd_mux[13:0] = alm_cur[1];
      `BWM_A_ALM2_LIM:  rd_mux[16:0] = alm_lim[1];
      `BWM_A_CAPACITY:  rd_mux[13:0] = capacity;
      `BWM_A_STATUS:    rd_mux[4:0]  = status;
      `BWM_A_MASK:      rd_mux[4:0]  = mask;
      `BWM_A_STATE:     rd_mux[4:0]  = {trip_pend, clr_pend, state != ST_IDLE, alarm_o};
      `BWM_A_TRIP_TIME: rd_mux       = trip_time;
      `BWM_A_TRIP_I1:   rd_mux[13:0] = trip_cur.phase1_broken_current;
      `BWM_A_TRIP_I2:   rd_mux[13:0] = trip_cur.phase2_broken_current;
      `BWM_A_TRIP_I3:   rd_mux[13:0] = trip_cur.phase3_broken_current;
      default: begin
        if (a_curve) begin
          rd_mux[16:0] = avs_address_i[2] ? pt_cnt[a_pt] : {3'h0, pt_cur[a_pt]};
        end else if (a_ops) begin
          rd_mux[16:0] = ops_left[a_ops_ix];
        end
      end
    endcase
  end

  // Waitrequest drops for one cycle after a request is seen; data is ready then.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
    end else begin
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
      avs_readdata_o    <= rd_mux;
    end
  end

  // ****************************************************************************
  // Configuration registers
  // ****************************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      evt_en   <= 4'h0;
      trip_sel <= 3'h0;
      capacity <= `BWM_CUR_MAX;
      mask     <= 5'h0;
      alm_cur  <= '{`BWM_CUR_MAX, `BWM_CUR_MAX};
      alm_lim  <= '{`BWM_LIM_MIN, `BWM_LIM_MIN};
    end else if (wr) begin
      case (avs_address_i)
        `BWM_A_CTRL: begin
          evt_en   <= wdat[`BWM_CTRL_EN +: 4];
          trip_sel <= wdat[`BWM_CTRL_SEL +: 3];
        end
        `BWM_A_ALM1_CUR: alm_cur[0] <= clamp_cur(wdat);
        `BWM_A_ALM1_LIM: alm_lim[0] <= clamp_lim(wdat);
        `BWM_A_ALM2_CUR: alm_cur[1] <= clamp_cur(wdat);
        `BWM_A_ALM2_LIM: alm_lim[1] <= clamp_lim(wdat);
        `BWM_A_CAPACITY: capacity   <= clamp_cur(wdat);
        `BWM_A_MASK:     mask       <= wdat[4:0];
        default: begin
        end
      endcase
    end
  end

  // Eight curve points, reset to the maximum current with count one.
  generate
    for (genvar k = 0; k < 8; k++) begin : g_pt
      always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          pt_cur[k] <= `BWM_CUR_MAX;
          pt_cnt[k] <= `BWM_CNT_UNUSED;
        end else if (wr & a_curve & (a_pt == 3'(k))) begin
          if (avs_address_i[2]) begin
            pt_cnt[k] <= wdat[16:0];
          end else begin
            pt_cur[k] <= clamp_cur(wdat);
          end
        end
      end
    end
  endgenerate

  // ****************************************************************************
  // Trip capture
  // ****************************************************************************
  wire logic trip_rise = trip_i[trip_sel] & ~trip_q;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      trip_q    <= 1'b0;
      trip_time <= 32'h0;
      trip_cur  <= '0;
    end else begin
      trip_q <= trip_i[trip_sel];
      if (trip_rise) begin
        trip_cur  <= broken_current_i;
        trip_time <= time_stamp_i;
      end
    end
  end

  // ****************************************************************************
  // Curve segment search and logarithms
  // ****************************************************************************
  wire logic [13:0] job_i   [0:2];
  wire logic [13:0] query;
  wire logic [7:0]  valid;
  wire logic [6:0]  hit;
  wire logic [16:0] op      [0:4];
  wire logic [12:0] lg      [0:4];
  wire logic [2:0]  seg_nx  = seg + 3'h1;

  assign job_i[0] = job_cur.phase1_broken_current;
  assign job_i[1] = job_cur.phase2_broken_current;
  assign job_i[2] = job_cur.phase3_broken_current;
  assign query    = (qidx < `BWM_Q_PHASE0) ? alm_cur[qidx[0]] :
                    job_i[2'(qidx - `BWM_Q_PHASE0)];

  function automatic [2:0] first_hit(input logic [6:0] h);
    first_hit = 3'h1;
    for (int i = 6; i >= 1; i--) begin
      if (h[i]) begin
        first_hit = 3'(i);
      end
    end
  endfunction : first_hit

  function automatic [2:0] last_valid(input logic [7:0] v);
    last_valid = 3'h1;
    for (int i = 1; i < 8; i++) begin
      if (v[i]) begin
        last_valid = 3'(i);
      end
    end
  endfunction : last_valid

  generate
    for (genvar k = 0; k < 8; k++) begin : g_valid
      assign valid[k] = ~((pt_cur[k] > capacity) & (pt_cnt[k] == `BWM_CNT_UNUSED));
    end
    for (genvar k = 0; k < 7; k++) begin : g_hit
      if (k == 0) begin : g_none
        assign hit[k] = 1'b0;
      end else begin : g_seg
        assign hit[k] = valid[k] & valid[k+1] & (query >= pt_cur[k]) &
                        (query < pt_cur[k+1]);
      end
    end
    for (genvar i = 0; i < 5; i++) begin : g_log
      bwm_log2 u_log (
        .value_i (op[i]),
        .log_o   (lg[i])
      );
    end
  endgenerate

  assign op[0] = {3'h0, query};
  assign op[1] = {3'h0, pt_cur[seg]};
  assign op[2] = {3'h0, pt_cur[seg_nx]};
  assign op[3] = flat ? flat_cnt : pt_cnt[seg];
  assign op[4] = pt_cnt[seg_nx];

  // log C = log Ck - (log I - log Ik) * n, with n = (log Ck - log Ck+1) / (log Ik+1 - log Ik).
  wire logic [12:0] d_i   = (lg[0] > lg[1]) ? 13'(lg[0] - lg[1]) : 13'h0;
  wire logic [12:0] d_c   = (lg[3] > lg[4]) ? 13'(lg[3] - lg[4]) : 13'h0;
  wire logic [12:0] d_s   = (lg[2] > lg[1]) ? 13'(lg[2] - lg[1]) : 13'h0;
  wire logic [25:0] prod  = (flat | (d_s == 13'h0)) ? 26'h0 : 26'(d_i * d_c);
  wire logic [39:0] div_sh = {div[38:0], 1'b0};
  wire logic        div_ge = div_sh[39:26] >= {1'b0, dvs};
  wire logic [13:0] div_rm = 14'(div_sh[39:26] - {1'b0, dvs});
  wire logic [25:0] quo    = div[25:0];

  // ****************************************************************************
  // Wear engine
  // ****************************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state     <= ST_IDLE;
      clr_pend  <= 1'b0;
      trip_pend <= 1'b0;
      job_trip  <= 1'b0;
      job_cur   <= '0;
      qidx      <= 3'h0;
      seg       <= 3'h1;
      flat      <= 1'b0;
      flat_cnt  <= `BWM_CNT_UNUSED;
      base      <= 13'h0;
      dvs       <= 13'h1;
      div       <= 40'h0;
      step      <= 5'h0;
      logres    <= '{5{13'h0}};
    end else begin
      // A new command arriving as the engine starts is kept: set wins.
      clr_pend  <= clr_cmd | (clr_pend & ~((state == ST_IDLE) & clr_pend));
      trip_pend <= trip_rise | (trip_pend & ~((state == ST_IDLE) & ~clr_pend & trip_pend));
      case (state)
        ST_IDLE: begin
          qidx <= 3'h0;
          if (clr_pend | trip_pend) begin
            job_trip <= ~clr_pend;
            job_cur  <= trip_cur;
            state    <= ST_SEG;
          end
        end
        ST_SEG: begin
          seg      <= first_hit(hit);
          flat     <= ~|hit;
          flat_cnt <= (query < pt_cur[1]) ? pt_cnt[1] : pt_cnt[last_valid(valid)];
          state    <= ST_MUL;
        end
        ST_MUL: begin
          base  <= lg[3];
          dvs   <= (d_s == 13'h0) ? 13'h1 : d_s;
          div   <= {14'h0, prod};
          step  <= 5'h0;
          state <= ST_DIV;
        end
        ST_DIV: begin
          div   <= div_ge ? {div_rm, div_sh[25:1], 1'b1} : div_sh;
          step  <= step + 5'h1;
          state <= (step == `BWM_DIV_LAST) ? ST_STORE : ST_DIV;
        end
        ST_STORE: begin
          logres[qidx] <= (quo > 26'(base)) ? 13'h0 : 13'(base - quo[12:0]);
          qidx         <= qidx + 3'h1;
          state        <= (qidx == (job_trip ? `BWM_Q_LAST_TRIP : `BWM_Q_LAST_CLR)) ?
                          ST_APPLY : ST_SEG;
        end
        ST_APPLY: state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************************
  // Operations-left counters, index = channel * 3 + phase
  // ****************************************************************************
  generate
    for (genvar c = 0; c < 2; c++) begin : g_ch
      for (genvar p = 0; p < 3; p++) begin : g_ph
        wire logic [12:0] ld    = (logres[c] > logres[p+2]) ?
                                  13'(logres[c] - logres[p+2]) : 13'h0;
        wire logic [16:0] ratio = exp2r(ld);
        wire logic [16:0] dec   = (job_i[p] < alm_cur[c]) ? `BWM_DEC_ONE : ratio;
        wire logic [16:0] cur   = ops_left[c*3+p];
        always_ff @(posedge core_clk_i or negedge rst_n) begin
          if (!rst_n) begin
            ops_left[c*3+p] <= `BWM_OPS_RST;
          end else if (state == ST_APPLY) begin
            if (!job_trip) begin
              ops_left[c*3+p] <= exp2r(logres[c]);
            end else begin
              ops_left[c*3+p] <= (cur > dec) ? 17'(cur - dec) : 17'h0;
            end
          end
        end
      end
    end
  endgenerate

  // ****************************************************************************
  // Alarms, events and interrupt
  // ****************************************************************************
  wire logic [1:0] next_alarm;
  wire logic [3:0] edge_evt;

  generate
    for (genvar c = 0; c < 2; c++) begin : g_alm
      assign next_alarm[c] = min3(ops_left[c*3], ops_left[c*3+1], ops_left[c*3+2]) <
                             alm_lim[c];
      assign edge_evt[c*2]   = next_alarm[c] & ~alarm_o[c];
      assign edge_evt[c*2+1] = ~next_alarm[c] & alarm_o[c];
    end
  endgenerate

  wire logic [4:0] evt_src = {(state == ST_APPLY) & job_trip, edge_evt};

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      alarm_o <= 2'h0;
      event_o <= '0;
      status  <= 5'h0;
      irq_o   <= 1'b0;
    end else begin
      alarm_o <= next_alarm;
      event_o.alarm_on  <= {edge_evt[2], edge_evt[0]} & {evt_en[2], evt_en[0]};
      event_o.alarm_off <= {edge_evt[3], edge_evt[1]} & {evt_en[3], evt_en[1]};
      // Write-one-to-clear; an event in the same cycle keeps its bit set.
      status <= evt_src | (status & ~(st_w1c ? wdat[4:0] : 5'h0));
      irq_o  <= |(status & mask);
    end
  end

endmodule : bwm_monitor

// [bwm_monitor_checker.sv]
/* Port assertions of bwm_monitor. Assumes one clock and the bind below. */
`timescale 1ns/1ps
module bwm_checker
  import bwm_pkg::*;
(
  // Watched ports
  input wire logic          core_clk_i,
  input wire logic          arst_n_i,
  input wire logic [7:0]    avs_address_i,
  input wire logic          avs_read_i,
  input wire logic          avs_write_i,
  input wire logic [31:0]   avs_readdata_o,
  input wire logic          avs_waitrequest_o,
  input wire logic [1:0]    alarm_o,
  input wire bwm_event_type event_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence req_s; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
  sequence ack_s; !avs_waitrequest_o; endsequence
  a_bus_answer: assert property (req_s |=> ack_s) else $error("bus request unanswered");
  a_bus_single: assert property (ack_s |=> !ack_s) else $error("wait low two cycles");
  a_bus_idle: assert property (!avs_read_i && !avs_write_i |=> avs_waitrequest_o)
    else $error("answer without request");
  a_unmapped_zero: assert property ((avs_read_i && avs_address_i == 8'h34) and ack_s
    |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  a_event_pulse: assert property (event_o != 4'h0 |=> event_o == 4'h0)
    else $error("event longer than one cycle");
  a_set_rose: assert property ((event_o.alarm_on & ~(alarm_o & ~$past(alarm_o))) == 2'b00)
    else $error("set event without alarm rise");
  a_clear_fell: assert property ((event_o.alarm_off & ~($past(alarm_o) & ~alarm_o)) == 2'b00)
    else $error("clear event without alarm fall");
  a_event_excl: assert property ((event_o.alarm_on & event_o.alarm_off) == 2'b00)
    else $error("set and clear event together");
endmodule : bwm_checker
bind bwm_monitor bwm_checker u_bwm_checker (.core_clk_i, .arst_n_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .alarm_o, .event_o);

// [bwm_partner.sv]
/* Trip logic model. Assumes the monitor samples on the same clock. */
`timescale 1ns/1ps
module bwm_partner
  import bwm_pkg::*;
(
  // Trip side
  input  wire logic         clk_i,
  output logic [7:0]        trip_o,
  output bwm_phase_cur_type cur_o,
  output logic [31:0]       stamp_o
);
  initial begin
    trip_o = 8'h00;
    cur_o = '0;
    stamp_o = 32'h0;
  end
  // Values are inverted after the trip so a late capture shows up.
  task automatic fire(input bwm_phase_cur_type c, input logic [31:0] t);
    @(posedge clk_i);
    cur_o <= c;
    stamp_o <= t;
    trip_o <= 8'h01;
    repeat (4) @(posedge clk_i);
    trip_o <= 8'h00;
    cur_o <= ~c;
    stamp_o <= ~t;
  endtask : fire
endmodule : bwm_partner

// [breaker_wear_monitor_test.sv]
/* Testbench of bwm_monitor. Assumes bwm_partner and the bound checker. */
`timescale 1ns/1ps
module breaker_wear_monitor_test
  import bwm_pkg::*;
;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, wq, irq, seen_on = 0;
  logic [7:0] ad = 8'h00, trip;
  logic [31:0] wd = 32'h0, rq, q, ts, pre [6];
  logic [1:0] alm;
  bwm_event_type ev;
  bwm_phase_cur_type cur;
  int miscompares = 0, tests_run = 0, cyc = 0;
  bwm_monitor u_bwm_monitor (.core_clk_i(clk), .arst_n_i(rst_n), .avs_address_i(ad),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rq), .avs_waitrequest_o(wq), .trip_i(trip), .broken_current_i(cur),
    .time_stamp_i(ts), .alarm_o(alm), .event_o(ev), .irq_o(irq));
  bwm_partner u_bwm_partner (.clk_i(clk), .trip_o(trip), .cur_o(cur), .stamp_o(ts));
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (ev.alarm_on[1] === 1'b1) seen_on <= 1'b1;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
  // ****
  // Bus and compare tasks
  // ****
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= d;
    do @(posedge clk); while (wq !== 1'b0);
    q = rq;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic chk_in(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    tests_run++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, lo);
    end
  endtask : chk_in
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk_in(q, e, e);
  endtask : rdc
  task automatic wait_idle;
    for (int i = 0; i < 100 && q[4:2] !== 3'b000; i++) bus(1'b0, 8'h20, 32'h0);
    chk_in({29'h0, q[4:2]}, 32'h0, 32'h0);
  endtask : wait_idle
  // Reads the six counters; the first call checks levels, the second the decrements.
  task automatic scan(input bit dec, input int lo [6], input int hi [6]);
    for (int j = 0; j < 6; j++) begin
      bus(1'b0, 8'h40 + 8'(j < 3 ? 4 * j : 4 * j + 4), 32'h0);
      chk_in(dec ? pre[j] - q : q, lo[j], hi[j]);
      pre[j] = q;
    end
  endtask : scan
  task automatic t_reset;
    rdc(8'h40, 32'h186a0);
    rdc(8'h34, 32'h0);
    bus(1'b1, 8'h08, 32'h0);
    rdc(8'h08, 32'h1);
    bus(1'b1, 8'h10, 32'h3ffff);
    rdc(8'h10, 32'h186a0);
    bus(1'b1, 8'h04, 32'h3fff);
    rdc(8'h04, 32'h2710);
    $display("reset test done");
  endtask : t_reset
  task automatic t_clear;
    logic [7:0] a [11] = '{8'h14, 8'h80, 8'h84, 8'h88, 8'h8c, 8'h90, 8'h94, 8'h04,
                           8'h0c, 8'h10, 8'h00};
    logic [31:0] d [11] = '{32'h1388, 32'h0, 32'h2710, 32'h7d, 32'h2710, 32'hc1c,
                            32'h50, 32'h7d, 32'h258, 32'h3e8, 32'h9};
    for (int i = 0; i < 11; i++) bus(1'b1, a[i], d[i]);
    q = 32'hff;
    wait_idle();
    scan(1'b0, '{9900, 9900, 9900, 935, 935, 935}, '{10100, 10100, 10100, 955, 955, 955});
    chk_in({30'h0, alm}, 32'h2, 32'h2);
    chk_in({31'h0, seen_on}, 32'h1, 32'h1);
    chk_in({31'h0, irq}, 32'h0, 32'h0);
    $display("clear test done");
  endtask : t_clear
  task automatic t_trip;
    bus(1'b1, 8'h1c, 32'h10);
    u_bwm_partner.fire({14'h96, 14'h4e2, 14'h4e2}, 32'h1234abcd);
    q = 32'hff;
    wait_idle();
    scan(1'b1, '{30, 30, 1, 3, 3, 1}, '{34, 34, 1, 3, 3, 1});
    rdc(8'h24, 32'h1234abcd);
    rdc(8'h28, 32'h4e2);
    rdc(8'h30, 32'h96);
    chk_in({31'h0, irq}, 32'h1, 32'h1);
    bus(1'b1, 8'h18, 32'h1f);
    repeat (2) @(posedge clk);
    chk_in({31'h0, irq}, 32'h0, 32'h0);
    bus(1'b1, 8'h00, 32'h10);
    bus(1'b1, 8'h10, 32'h1);
    rdc(8'h18, 32'h8);
    chk_in({30'h0, alm}, 32'h0, 32'h0);
    $display("trip test done");
  endtask : t_trip
  task automatic conclude;
    $display("tests %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_clear();
    t_trip();
    conclude();
  end
endmodule : breaker_wear_monitor_test
